// >>> include/scp_cfg.svh
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCP_ADDR_W 4
`define SCP_OFF_SYSCTL0 4'h0
`define SCP_OFF_PLLCTL0 4'h4
`define SCP_OFF_PLLCTL1 4'h8
`define SCP_OFF_STATUS 4'hc

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define SCP_K1_W 10
`define SCP_K2_W 4
`define SCP_PLL_INPUT_DIVIDER_W 4
`define SCP_PLL_FEEDBACK_MULTIPLIER_W 7
`define SCP_BIT_VCO_BYPASS 0
`define SCP_BIT_OSCINT 1
`define SCP_PLL_INPUT_DIVIDER_LSB 4
`define SCP_PLL_FEEDBACK_MULTIPLIER_LSB 8
`define SCP_K2_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCP_RST_SEL 2'h0
`define SCP_RST_VCO_BYPASS 1'h1
`define SCP_RST_OSCINT 1'h0
`define SCP_RST_K1 10'h000
`define SCP_RST_K2 4'h0
`define SCP_RST_PLL_INPUT_DIVIDER 4'h0
`define SCP_RST_PLL_FEEDBACK_MULTIPLIER 7'h00

// ----------------------------------------------------------------
// Sampled clock pin indices
// ----------------------------------------------------------------
`define SCP_NSRC 5
`define SCP_SRC_DIRECT 0
`define SCP_SRC_XTAL 1
`define SCP_SRC_INTOSC 2
`define SCP_SRC_WAKEUP 3
`define SCP_SRC_VCO 4

`endif

// >>> include/scp_pkg.sv
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_SEL_WAKEUP = 2'h0,
    SCP_SEL_RSVD = 2'h1,
    SCP_SEL_PRESCALE = 2'h2,
    SCP_SEL_DIRECT = 2'h3
  } scp_sel_type;
endpackage

// >>> hw/scp_sysclk.sv
// Contract
// R1 - Select 11 passes direct clock input
// R2 - Direct drive keeps incoming duty cycle
// R3 - Select 10, bypass 1 uses oscillator
// R4 - Prescaler divides by divider field plus one
// R5 - Factor one passes oscillator unchanged
// R6 - Divider reaches factor 1024 at most
// R7 - Crystal bypass factor one equals direct
// R8 - Select 10, bypass 0 outputs PLL clock
// R9 - Select 00 passes wakeup clock
// R10 - Config changes only at period boundary
//
// Our own choices: the address-and-strobe port and the register addresses.
`include "scp_cfg.svh"

module scp_sysclk (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic DIRECT_CLOCK_INPUT,
  input wire logic CRYSTAL_INPUT,
  input wire logic INTERNAL_OSC_CLOCK,
  input wire logic WAKEUP_CLOCK,
  input wire logic VCO_CLOCK,
  input wire logic [`SCP_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WRITE_DATA,
  input wire logic WRITE_STROBE,
  input wire logic READ_STROBE,
  output logic [31:0] READ_DATA,
  output logic SYS_CLOCK_OUT,
  output logic [`SCP_PLL_INPUT_DIVIDER_W-1:0] PLL_INPUT_DIVIDER,
  output logic [`SCP_PLL_FEEDBACK_MULTIPLIER_W-1:0] PLL_FEEDBACK_MULTIPLIER
);

  // ----------------------------------------------------------------
  // Reset release and pin sampling
  // ----------------------------------------------------------------
  logic rst_meta_ff, rst_sync_ff, rst_n;
  logic [`SCP_NSRC-1:0] pins, s1_ff, s2_ff, s3_ff;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  assign pins = {VCO_CLOCK, WAKEUP_CLOCK, INTERNAL_OSC_CLOCK,
                 CRYSTAL_INPUT, DIRECT_CLOCK_INPUT};

  genvar gi;
  generate
    for (gi = 0; gi < `SCP_NSRC; gi = gi + 1) begin : g_sync
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi] <= pins[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Programmed configuration
  // ----------------------------------------------------------------
  scp_pkg::scp_sel_type sel_ff;
  logic byp_ff, oscint_ff;
  logic [`SCP_K1_W-1:0] k1_ff;
  logic [`SCP_K2_W-1:0] k2_ff;
  logic [`SCP_PLL_INPUT_DIVIDER_W-1:0] pll_input_divider_ff;
  logic [`SCP_PLL_FEEDBACK_MULTIPLIER_W-1:0] pll_feedback_multiplier_ff;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= scp_pkg::scp_sel_type'(`SCP_RST_SEL);
      byp_ff <= `SCP_RST_VCO_BYPASS;
      oscint_ff <= `SCP_RST_OSCINT;
      k1_ff <= `SCP_RST_K1;
      k2_ff <= `SCP_RST_K2;
      pll_input_divider_ff <= `SCP_RST_PLL_INPUT_DIVIDER;
      pll_feedback_multiplier_ff <= `SCP_RST_PLL_FEEDBACK_MULTIPLIER;
    end else if (WRITE_STROBE) begin
      unique case (ADDR)
        `SCP_OFF_SYSCTL0: sel_ff <= scp_pkg::scp_sel_type'(WRITE_DATA[1:0]);
        `SCP_OFF_PLLCTL0: begin
          byp_ff <= WRITE_DATA[`SCP_BIT_VCO_BYPASS];
          oscint_ff <= WRITE_DATA[`SCP_BIT_OSCINT];
          pll_input_divider_ff <= WRITE_DATA[`SCP_PLL_INPUT_DIVIDER_LSB +: `SCP_PLL_INPUT_DIVIDER_W];
          pll_feedback_multiplier_ff <= WRITE_DATA[`SCP_PLL_FEEDBACK_MULTIPLIER_LSB +: `SCP_PLL_FEEDBACK_MULTIPLIER_W];
          k2_ff <= WRITE_DATA[`SCP_K2_LSB +: `SCP_K2_W];
        end
        `SCP_OFF_PLLCTL1: k1_ff <= WRITE_DATA[`SCP_K1_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active configuration, source choice and divider
  // ----------------------------------------------------------------
  scp_pkg::scp_sel_type act_sel_ff;
  logic act_byp_ff, act_int_ff, out_ff;
  logic [`SCP_K1_W-1:0] act_k1_ff, cnt_ff, limit;
  logic [`SCP_K2_W-1:0] act_k2_ff;
  logic src_lvl, src_prev, pass, idle, tick, rise, boundary, load;
  logic cfg_diff;

  always_comb begin
    src_lvl = 1'b0;
    src_prev = 1'b0;
    limit = '0;
    idle = 1'b0;
    unique case (act_sel_ff)
      scp_pkg::SCP_SEL_DIRECT: begin
        src_lvl = s2_ff[`SCP_SRC_DIRECT]; // [R1]
        src_prev = s3_ff[`SCP_SRC_DIRECT];
      end
      scp_pkg::SCP_SEL_WAKEUP: begin
        src_lvl = s2_ff[`SCP_SRC_WAKEUP]; // [R9]
        src_prev = s3_ff[`SCP_SRC_WAKEUP];
      end
      scp_pkg::SCP_SEL_PRESCALE: begin
        if (act_byp_ff) begin
          // Oscillator through output prescaler
          src_lvl = act_int_ff ? s2_ff[`SCP_SRC_INTOSC]
                               : s2_ff[`SCP_SRC_XTAL]; // [R3]
          src_prev = act_int_ff ? s3_ff[`SCP_SRC_INTOSC]
                                : s3_ff[`SCP_SRC_XTAL];
          limit = act_k1_ff; // [R4] [R6]
        end else begin
          // Analogue loop does N/P; only K2 is digital
          src_lvl = s2_ff[`SCP_SRC_VCO]; // [R8]
          src_prev = s3_ff[`SCP_SRC_VCO];
          limit = {{(`SCP_K1_W-`SCP_K2_W){1'b0}}, act_k2_ff}; // [R8]
        end
      end
      scp_pkg::SCP_SEL_RSVD: idle = 1'b1;
    endcase
  end

  // Edge counting: limit+1 half periods per output phase
  assign pass = (limit == '0); // [R5] [R7]
  assign tick = (src_lvl != src_prev);
  assign rise = pass ? (tick & src_lvl)
                     : (tick & (cnt_ff == limit) & ~out_ff);
  assign boundary = ~out_ff & (rise | idle);
  assign cfg_diff = (sel_ff != act_sel_ff) || (byp_ff != act_byp_ff) ||
                    (oscint_ff != act_int_ff) || (k1_ff != act_k1_ff) ||
                    (k2_ff != act_k2_ff);
  // Swap at a rising boundary; the rise is skipped so nothing is cut short
  assign load = boundary & cfg_diff; // [R10]

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      act_sel_ff <= scp_pkg::scp_sel_type'(`SCP_RST_SEL);
      act_byp_ff <= `SCP_RST_VCO_BYPASS;
      act_int_ff <= `SCP_RST_OSCINT;
      act_k1_ff <= `SCP_RST_K1;
      act_k2_ff <= `SCP_RST_K2;
    end else if (load) begin // [R10]
      act_sel_ff <= sel_ff;
      act_byp_ff <= byp_ff;
      act_int_ff <= oscint_ff;
      act_k1_ff <= k1_ff;
      act_k2_ff <= k2_ff;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (load) begin
      out_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (pass) begin
      // Edges copied one for one, so duty follows the source
      if (tick) out_ff <= src_lvl; // [R1] [R2] [R5] [R7] [R9]
      cnt_ff <= '0;
    end else if (tick) begin
      if (cnt_ff == limit) begin
        out_ff <= ~out_ff; // [R4] [R6]
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (READ_STROBE) begin
      unique case (ADDR)
        `SCP_OFF_SYSCTL0: nxt_rdata[1:0] = sel_ff;
        `SCP_OFF_PLLCTL0: begin
          nxt_rdata[`SCP_BIT_VCO_BYPASS] = byp_ff;
          nxt_rdata[`SCP_BIT_OSCINT] = oscint_ff;
          nxt_rdata[`SCP_PLL_INPUT_DIVIDER_LSB +: `SCP_PLL_INPUT_DIVIDER_W] = pll_input_divider_ff;
          nxt_rdata[`SCP_PLL_FEEDBACK_MULTIPLIER_LSB +: `SCP_PLL_FEEDBACK_MULTIPLIER_W] = pll_feedback_multiplier_ff;
          nxt_rdata[`SCP_K2_LSB +: `SCP_K2_W] = k2_ff;
        end
        `SCP_OFF_PLLCTL1: nxt_rdata[`SCP_K1_W-1:0] = k1_ff;
        `SCP_OFF_STATUS: nxt_rdata[4:0] = {cfg_diff, out_ff,
                                           act_byp_ff, act_sel_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign READ_DATA = rdata_ff;
  assign SYS_CLOCK_OUT = out_ff;
  assign PLL_INPUT_DIVIDER = pll_input_divider_ff; // [R8]
  assign PLL_FEEDBACK_MULTIPLIER = pll_feedback_multiplier_ff; // [R8]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  a_direct_follow: assert property ( // [R1]
    (act_sel_ff == scp_pkg::SCP_SEL_DIRECT && tick && !load)
      |=> out_ff == $past(s2_ff[`SCP_SRC_DIRECT]))
    else $error("direct drive output does not follow pin");

  a_direct_no_reshape: assert property ( // [R2]
    (act_sel_ff == scp_pkg::SCP_SEL_DIRECT && !tick && !load)
      |=> $stable(out_ff))
    else $error("direct drive output moved without input edge");

  a_presc_source: assert property ( // [R3]
    (act_sel_ff == scp_pkg::SCP_SEL_PRESCALE && act_byp_ff)
      |-> src_lvl == (act_int_ff ? s2_ff[`SCP_SRC_INTOSC]
                                 : s2_ff[`SCP_SRC_XTAL]))
    else $error("prescaler mode uses wrong source");

  a_divide_toggle: assert property ( // [R4]
    (!pass && tick && cnt_ff == limit && !load)
      |=> out_ff != $past(out_ff) && cnt_ff == '0)
    else $error("divider did not toggle at terminal count");

  a_unity_pass: assert property ( // [R5]
    (act_sel_ff == scp_pkg::SCP_SEL_PRESCALE && act_byp_ff &&
     act_k1_ff == '0 && tick && !load)
      |=> out_ff == $past(src_lvl))
    else $error("factor one does not pass oscillator");

  a_count_bound: assert property ( // [R6]
    (!pass && tick && cnt_ff < limit && !load)
      |=> $stable(out_ff) && cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("divider count or output wrong");

  a_xtal_bypass: assert property ( // [R7]
    (act_sel_ff == scp_pkg::SCP_SEL_PRESCALE && act_byp_ff &&
     !act_int_ff && act_k1_ff == '0 && tick && !load)
      |=> out_ff == $past(s2_ff[`SCP_SRC_XTAL]))
    else $error("crystal bypass does not pass straight through");

  a_pll_source: assert property ( // [R8]
    (act_sel_ff == scp_pkg::SCP_SEL_PRESCALE && !act_byp_ff)
      |-> src_lvl == s2_ff[`SCP_SRC_VCO] && limit == act_k2_ff)
    else $error("PLL mode uses wrong source or divider");

  a_wakeup_follow: assert property ( // [R9]
    (act_sel_ff == scp_pkg::SCP_SEL_WAKEUP && tick && !load)
      |=> out_ff == $past(s2_ff[`SCP_SRC_WAKEUP]))
    else $error("wakeup mode output does not follow source");

  a_switch_boundary: assert property ( // [R10]
    (!$stable(act_sel_ff) || !$stable(act_k1_ff) || !$stable(act_byp_ff) ||
     !$stable(act_int_ff) || !$stable(act_k2_ff))
      |-> !$past(out_ff) && !out_ff && cnt_ff == '0)
    else $error("configuration changed mid period");

endmodule

// >>> testbench/scp_osc_model.sv
// ----------------------------------------------------------------
// One free-running clock source seen from the far side
// ----------------------------------------------------------------
module scp_osc_model #(
  parameter int HI = 2,
  parameter int LO = 2
) (
  input wire logic mclk,
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt = 0;

  initial clk_out = 1'b0;

  // Halves kept at 2 or more cycles so the sampler never misses an edge
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    if ((clk_out && cnt >= HI - 1) || (!clk_out && cnt >= LO - 1)) begin
      clk_out <= !clk_out;
      cnt <= 0;
    end
  end
endmodule

// >>> testbench/system_clock_source_prescaler_tb.sv
module system_clock_source_prescaler_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Source shapes: direct, crystal, internal, wakeup, vco
  // ----------------------------------------------------------------
  localparam int HI[5] = '{3, 2, 2, 7, 2};
  localparam int LO[5] = '{5, 4, 2, 7, 2};
  localparam int LIM = 40000;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic sys_clk;
  logic [3:0] pll_p;
  logic [6:0] pll_n;
  logic [4:0] src;
  logic [31:0] rv;
  int err_total = 0;
  int n_compared = 0;
  int hi, lo, k, o, p, n, k2;

  always #5 mclk = ~mclk;

  for (genvar g = 0; g < 5; g++) begin : g_src
    scp_osc_model #(.HI(HI[g]), .LO(LO[g])) scp_osc_model_i (
      .mclk(mclk),
      .clk_out(src[g])
    );
  end

  scp_sysclk scp_sysclk_i (
    .MCLK(mclk),
    .RESET_N(reset_n),
    .DIRECT_CLOCK_INPUT(src[0]),
    .CRYSTAL_INPUT(src[1]),
    .INTERNAL_OSC_CLOCK(src[2]),
    .WAKEUP_CLOCK(src[3]),
    .VCO_CLOCK(src[4]),
    .ADDR(addr),
    .WRITE_DATA(wdata),
    .WRITE_STROBE(wr_stb),
    .READ_STROBE(rd_stb),
    .READ_DATA(rdata),
    .SYS_CLOCK_OUT(sys_clk),
    .PLL_INPUT_DIVIDER(pll_p),
    .PLL_FEEDBACK_MULTIPLIER(pll_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int exp_per(input int f, input int s);
    return f * (HI[s] + LO[s]);
  endfunction

  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Poll until the pending swap has landed
  task automatic settle();
    for (int i = 0; i < LIM / 2; i++) begin
      rd(4'hc, rv);
      if (rv[4] === 1'b0)
        return;
    end
    err_total++;
    conclude();
  endtask

  // Skips the partial pulse, then times one whole high and low
  task automatic meas();
    int t;
    t = 0;
    hi = 0;
    lo = 0;
    @(negedge mclk);
    while (sys_clk !== 1'b0 && t < LIM) begin @(negedge mclk); t++; end
    while (sys_clk !== 1'b1 && t < LIM) begin @(negedge mclk); t++; end
    while (sys_clk === 1'b1 && t < LIM) begin @(negedge mclk); t++; hi++; end
    while (sys_clk === 1'b0 && t < LIM) begin @(negedge mclk); t++; lo++; end
    if (t >= LIM) begin
      err_total++;
      conclude();
    end
  endtask

  // Waits out the current high, then times the low that follows
  task automatic low_span();
    int t;
    t = 0;
    lo = 0;
    @(negedge mclk);
    while (sys_clk !== 1'b0 && t < LIM) begin @(negedge mclk); t++; end
    while (sys_clk === 1'b0 && t < LIM) begin @(negedge mclk); t++; lo++; end
    if (t >= LIM) begin
      err_total++;
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha1ca));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(4'h0, rv);
    chk(rv, 32'h0);
    rd(4'h4, rv);
    chk(rv, 32'h1);
    rd(4'h8, rv);
    chk(rv, 32'h0);
    rd(4'h2, rv);
    chk(rv, 32'h0);
    rd(4'hc, rv);
    chk(rv & 32'hfffffff7, 32'h4);
    meas();
    chk(32'(hi), 32'd7);
    chk(32'(lo), 32'd7);
    wr(4'h0, 32'h3);
    settle();
    meas();
    chk(32'(hi), 32'd3);
    chk(32'(lo), 32'd5);
    wr(4'h8, 32'h0);
    wr(4'h0, 32'h2);
    settle();
    meas();
    chk(32'(hi), 32'd2);
    chk(32'(lo), 32'd4);
    repeat (4) begin
      o = $urandom_range(1, 0);
      k = $urandom_range(15, 1);
      wr(4'h4, (o != 0) ? 32'h3 : 32'h1);
      wr(4'h8, 32'(k));
      settle();
      meas();
      chk(32'(hi + lo), 32'(exp_per(k + 1, o + 1)));
    end
    wr(4'h4, 32'h1);
    wr(4'h8, 32'h3ff);
    settle();
    meas();
    chk(32'(hi + lo), 32'(exp_per(1024, 1)));
    // Written mid-pulse: the next whole pulse must be the new shape
    wr(4'h8, 32'h3);
    low_span();
    chk(32'(lo >= exp_per(1024, 1) / 2), 32'h1);
    meas();
    chk(32'(hi + lo), 32'(exp_per(4, 1)));
    k2 = $urandom_range(15, 0);
    p = $urandom_range(15, 0);
    n = $urandom_range(127, 0);
    wr(4'h4, 32'((k2 << 16) | (n << 8) | (p << 4)));
    settle();
    meas();
    chk(32'(hi + lo), 32'(exp_per(k2 + 1, 4)));
    chk({28'h0, pll_p}, 32'(p));
    chk({25'h0, pll_n}, 32'(n));
    // Reserved select: swap at a boundary, then output held low
    wr(4'h0, 32'h1);
    settle();
    rd(4'hc, rv);
    chk(rv, 32'h1);
    hi = 0;
    repeat (40) begin
      @(negedge mclk);
      if (sys_clk !== 1'b0) hi++;
    end
    chk(32'(hi), 32'h0);
    conclude();
  end
endmodule
